// [rtl/osr_top.sv]
// Output selection, line sharing and status readback of the synthesizer.
// Assumes the serial core gives decoded writes/reads and readback state.
`timescale 1ns/1ps
module osr_top (
	input  wire logic                        CLK,
	input  wire logic                        RST,
	// Register access from the serial core
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	input  wire logic [osr_pkg::ADDR_W-1:0]  REG_ADDR,
	input  wire logic [osr_pkg::DATA_W-1:0]  REG_WDATA,
	output logic      [osr_pkg::DATA_W-1:0]  REG_RDATA,
	output logic                             REG_RVALID,
	// Readback state of the serial core
	input  wire logic                        SPI_READ_ACTIVE,
	input  wire logic                        SPI_READ_BIT,
	input  wire logic                        SPI_DRV_REQ,
	// Self-test engine, same clock
	input  wire logic [osr_pkg::SIG_W-1:0]   SELF_TEST_SIGNATURE,
	input  wire logic                        SELF_TEST_RUNNING,
	// Internal sources, other clocks
	input  wire logic                        LOCK_IND,
	input  wire logic                        LOCK_TRIG,
	input  wire logic                        LOCK_WIN,
	input  wire logic                        RING_OSC_TEST,
	input  wire logic                        CYCLE_SLIP_PULL_UP,
	input  wire logic                        CYCLE_SLIP_PULL_DN,
	input  wire logic                        REF_BUF_OUT,
	input  wire logic                        REF_DIV_OUT,
	input  wire logic                        FB_DIV_OUT,
	input  wire logic                        MOD_CLK,
	input  wire logic                        AUX_CLK,
	input  wire logic                        AUXP_CLK,
	input  wire logic                        AUXP_DATA,
	input  wire logic                        PHASE_DET_DN,
	input  wire logic                        PHASE_DET_UP,
	input  wire logic                        MOD_CLK_DLY,
	input  wire logic                        MOD_CORE_CLK,
	input  wire logic                        STROBE_INT,
	input  wire logic                        STROBE_FRAC,
	input  wire logic                        STROBE_AUX,
	input  wire logic                        SPI_LATCH_EN,
	input  wire logic                        FB_SYNC_RST,
	input  wire logic                        SEED_LOAD,
	input  wire logic                        SPI_OUT_BUF_EN,
	input  wire logic                        SOFT_RESET_LOW,
	// Data out pin and its driver controls
	output logic                             SDO_O,
	output logic                             SDO_OE,
	output logic                             PULLUP_TRANSISTOR_OFF,
	output logic                             PULLDOWN_TRANSISTOR_OFF
);
	localparam int DW = osr_pkg::DATA_W;

	logic [osr_pkg::CTRL_W-1:0] ctrl_q;
	logic [osr_pkg::CTRL_W-1:0] ctrl_d;
	logic [DW-1:0]              rdata_q;
	logic [DW-1:0]              rdata_d;
	logic                       rvalid_q;
	logic [osr_pkg::SIG_W-1:0]  sig_q;
	logic                       busy_q;
	logic                       sdo_q;
	logic                       sdo_d;
	logic                       oe_q;
	logic                       oe_d;

	osr_sel_if sif ();

	// Source vector indexed by selector code; unused codes stay low
	always_comb begin
		sif.src = '0;
		sif.src[osr_pkg::SRC_LOCK]      = LOCK_IND;
		sif.src[osr_pkg::SRC_LD_TRIG]   = LOCK_TRIG;
		sif.src[osr_pkg::SRC_LD_WIN]    = LOCK_WIN;
		sif.src[osr_pkg::SRC_RING]      = RING_OSC_TEST;
		sif.src[osr_pkg::SRC_SLIP_UP]   = CYCLE_SLIP_PULL_UP;
		sif.src[osr_pkg::SRC_SLIP_DN]   = CYCLE_SLIP_PULL_DN;
		sif.src[osr_pkg::SRC_REF_BUF]   = REF_BUF_OUT;
		sif.src[osr_pkg::SRC_REF_DIV]   = REF_DIV_OUT;
		sif.src[osr_pkg::SRC_FB_DIV]    = FB_DIV_OUT;
		sif.src[osr_pkg::SRC_MOD_CLK]   = MOD_CLK;
		sif.src[osr_pkg::SRC_AUX_CLK]   = AUX_CLK;
		sif.src[osr_pkg::SRC_AUXP_CLK]  = AUXP_CLK;
		sif.src[osr_pkg::SRC_AUXP_DAT]  = AUXP_DATA;
		sif.src[osr_pkg::SRC_PHDET_DN]  = PHASE_DET_DN;
		sif.src[osr_pkg::SRC_PHDET_UP]  = PHASE_DET_UP;
		sif.src[osr_pkg::SRC_MOD_DLY]   = MOD_CLK_DLY;
		sif.src[osr_pkg::SRC_MOD_CORE]  = MOD_CORE_CLK;
		sif.src[osr_pkg::SRC_STB_INT]   = STROBE_INT;
		sif.src[osr_pkg::SRC_STB_FRAC]  = STROBE_FRAC;
		sif.src[osr_pkg::SRC_STB_AUX]   = STROBE_AUX;
		sif.src[osr_pkg::SRC_LATCH]     = SPI_LATCH_EN;
		sif.src[osr_pkg::SRC_FB_SRST]   = FB_SYNC_RST;
		sif.src[osr_pkg::SRC_SEED]      = SEED_LOAD;
		sif.src[osr_pkg::SRC_OUT_EN]    = SPI_OUT_BUF_EN;
		sif.src[osr_pkg::SRC_SOFT_RSTN] = SOFT_RESET_LOW;
	end

	// Selector fields driven from the control register
	assign sif.sel      = ctrl_q[osr_pkg::SEL_LSB +: osr_pkg::SEL_W];
	assign sif.test_bit = ctrl_q[osr_pkg::TEST_BIT];

	osr_mux #(
		.NSRC (osr_pkg::NSRC)
	) u_mux (
		.clk (CLK),
		.rst (RST),
		.sif (sif)
	);

	// Decoded control fields
	wire inhibit_line_sharing = ctrl_q[osr_pkg::INHIBIT_BIT];
	wire keep_driver          = ctrl_q[osr_pkg::KEEP_DRV_BIT];
	wire wr_ctrl              = REG_WR && (REG_ADDR == osr_pkg::OFS_CTRL);
	wire lock_sync            = sif.src_sync[osr_pkg::SRC_LOCK];

	// Only the control register accepts writes; others ignore them
	assign ctrl_d = wr_ctrl ? REG_WDATA[osr_pkg::CTRL_W-1:0] : ctrl_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_q <= osr_pkg::CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Self-test results sampled each cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sig_q  <= '0;
			busy_q <= 1'b0;
		end else begin
			sig_q  <= SELF_TEST_SIGNATURE;
			busy_q <= SELF_TEST_RUNNING;
		end
	end

	// Read data selection; unmapped offsets read zero
	always_comb begin
		rdata_d = '0;
		unique case (REG_ADDR)
			osr_pkg::OFS_CTRL: begin
				rdata_d[osr_pkg::CTRL_W-1:0] = ctrl_q;
			end
			osr_pkg::OFS_RSV_A: begin
				rdata_d[osr_pkg::RSV_A_W-1:0] = osr_pkg::RSV_A_RST;
			end
			osr_pkg::OFS_RSV_B: begin
				rdata_d[osr_pkg::RSV_B_W-1:0] = osr_pkg::RSV_B_RST;
			end
			osr_pkg::OFS_STATUS: begin
				rdata_d[osr_pkg::STAT_OUT_BIT]  = sif.out;
				rdata_d[osr_pkg::STAT_LOCK_BIT] = lock_sync;
			end
			osr_pkg::OFS_SELF: begin
				rdata_d[osr_pkg::SIG_W-1:0]  = sig_q;
				rdata_d[osr_pkg::BUSY_BIT]   = busy_q;
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// Read answer one cycle after the request
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_q  <= '0;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= REG_RD;
			if (REG_RD) begin
				rdata_q <= rdata_d;
			end
		end
	end

	// Line sharing: readback owns the pin unless inhibited
	assign sdo_d = (SPI_READ_ACTIVE && !inhibit_line_sharing)
	             ? SPI_READ_BIT : sif.out;
	// Driver stays on when kept, else as the serial core asks
	assign oe_d  = keep_driver || SPI_DRV_REQ;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sdo_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			sdo_q <= sdo_d;
			oe_q  <= oe_d;
		end
	end

	assign REG_RDATA               = rdata_q;
	assign REG_RVALID              = rvalid_q;
	assign SDO_O                   = sdo_q;
	assign SDO_OE                  = oe_q;
	assign PULLUP_TRANSISTOR_OFF   = ctrl_q[osr_pkg::PFET_OFF_BIT];
	assign PULLDOWN_TRANSISTOR_OFF = ctrl_q[osr_pkg::NFET_OFF_BIT];
endmodule

// [include/osr_pkg.sv]
// Constants for the output selector and status readback block.
// Assumes the serial interface core delivers decoded register accesses.
package osr_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam int SEL_W  = 5;
	localparam int NSRC   = 32;

	// Register offsets
	localparam logic [5:0] OFS_CTRL   = 6'h0f;
	localparam logic [5:0] OFS_RSV_A  = 6'h10;
	localparam logic [5:0] OFS_RSV_B  = 6'h11;
	localparam logic [5:0] OFS_STATUS = 6'h12;
	localparam logic [5:0] OFS_SELF   = 6'h13;

	// Control register layout
	localparam int CTRL_W        = 10;
	localparam int SEL_LSB       = 0;
	localparam int TEST_BIT      = 5;
	localparam int INHIBIT_BIT   = 6;
	localparam int KEEP_DRV_BIT  = 7;
	localparam int PFET_OFF_BIT  = 8;
	localparam int NFET_OFF_BIT  = 9;
	localparam logic [9:0] CTRL_RST = 10'h001;

	// Status and self-test layout
	localparam int STAT_OUT_BIT  = 0;
	localparam int STAT_LOCK_BIT = 1;
	localparam int SIG_W         = 16;
	localparam int BUSY_BIT      = 16;
	localparam int RSV_A_W       = 9;
	localparam int RSV_B_W       = 19;
	localparam logic [8:0]  RSV_A_RST = 9'h000;
	localparam logic [18:0] RSV_B_RST = 19'h0_0000;

	// Selector codes
	localparam int SRC_TEST      = 0;
	localparam int SRC_LOCK      = 1;
	localparam int SRC_LD_TRIG   = 2;
	localparam int SRC_LD_WIN    = 3;
	localparam int SRC_RING      = 4;
	localparam int SRC_SLIP_UP   = 5;
	localparam int SRC_SLIP_DN   = 6;
	localparam int SRC_REF_BUF   = 8;
	localparam int SRC_REF_DIV   = 9;
	localparam int SRC_FB_DIV    = 10;
	localparam int SRC_MOD_CLK   = 11;
	localparam int SRC_AUX_CLK   = 12;
	localparam int SRC_AUXP_CLK  = 13;
	localparam int SRC_AUXP_DAT  = 14;
	localparam int SRC_PHDET_DN  = 16;
	localparam int SRC_PHDET_UP  = 17;
	localparam int SRC_MOD_DLY   = 18;
	localparam int SRC_MOD_CORE  = 19;
	localparam int SRC_STB_INT   = 20;
	localparam int SRC_STB_FRAC  = 21;
	localparam int SRC_STB_AUX   = 22;
	localparam int SRC_LATCH     = 23;
	localparam int SRC_FB_SRST   = 24;
	localparam int SRC_SEED      = 25;
	localparam int SRC_OUT_EN    = 30;
	localparam int SRC_SOFT_RSTN = 31;
endpackage

// [include/osr_sel_if.sv]
// Carrier between the control logic and the output selector.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface osr_sel_if;
	logic [osr_pkg::SEL_W-1:0] sel;
	logic                      test_bit;
	logic [osr_pkg::NSRC-1:0]  src;
	logic [osr_pkg::NSRC-1:0]  src_sync;
	logic                      out;

	modport mux (input sel, input test_bit, input src, output src_sync, output out);
	modport ctl (output sel, output test_bit, output src, input src_sync, input out);
endinterface

// [rtl/osr_mux.sv]
// Output selector: synchronises every source and picks one by code.
// Assumes sources come from other clocks or pins; test bit is local.
`timescale 1ns/1ps
module osr_mux #(
	parameter int NSRC = osr_pkg::NSRC
) (
	input  wire logic clk,
	input  wire logic rst,
	osr_sel_if.mux    sif
);
	logic [NSRC-1:0] meta_q;
	logic [NSRC-1:0] sync_q;
	logic            out_q;
	logic            out_d;
	logic            pick;

	// Two-stage synchroniser per source
	genvar i;
	generate
		for (i = 0; i < NSRC; i++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= sif.src[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	// Code 0 takes the local test bit, others the synced source
	assign pick  = sync_q[sif.sel];
	assign out_d = (sif.sel == '0) ? sif.test_bit : pick;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_q <= 1'b0;
		end else begin
			out_q <= out_d;
		end
	end

	assign sif.out      = out_q;
	assign sif.src_sync = sync_q;
endmodule

// [verif/osr_properties.sv]
// Checker for selection, line sharing and readback at the top ports.
// Assumes binding to osr_top; keeps its own shadow of the control register.
`timescale 1ns/1ps
module osr_properties (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [5:0]  REG_ADDR,
	input wire logic [23:0] REG_WDATA,
	input wire logic [23:0] REG_RDATA,
	input wire logic        REG_RVALID,
	input wire logic        SPI_READ_ACTIVE,
	input wire logic        SPI_READ_BIT,
	input wire logic        SPI_DRV_REQ,
	input wire logic [15:0] SELF_TEST_SIGNATURE,
	input wire logic        SELF_TEST_RUNNING,
	input wire logic        LOCK_IND,
	input wire logic        SDO_O,
	input wire logic        SDO_OE
);
	logic [9:0] ctrl_q;
	// Selected signal reaches the pin when readback is not sharing it
	wire        sel_path = !SPI_READ_ACTIVE || ctrl_q[6];
	wire        rsv_hit  = REG_ADDR < osr_pkg::OFS_CTRL || REG_ADDR > osr_pkg::OFS_SELF
		|| REG_ADDR == osr_pkg::OFS_RSV_A || REG_ADDR == osr_pkg::OFS_RSV_B;
	// Shadow of the control register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			ctrl_q <= osr_pkg::CTRL_RST;
		else if (REG_WR && REG_ADDR == osr_pkg::OFS_CTRL)
			ctrl_q <= REG_WDATA[9:0];
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	a_rvalid_after_read: assert property (REG_RVALID == $past(REG_RD))
		else $error("read valid not one cycle after read");
	a_oe_keep_driver: assert property (SDO_OE == ($past(ctrl_q[7]) | $past(SPI_DRV_REQ)))
		else $error("data out enable wrong");
	a_readback_share: assert property (SPI_READ_ACTIVE && !ctrl_q[6] |=> SDO_O == $past(SPI_READ_BIT))
		else $error("readback bit not on pin");
	a_test_bit_out: assert property (ctrl_q[4:0] == 5'h00 ##1 sel_path |=> SDO_O == $past(ctrl_q[5], 2))
		else $error("test bit not on pin");
	a_lock_path: assert property (ctrl_q[4:0] == 5'h01 ##1 sel_path |=> SDO_O == $past(LOCK_IND, 4))
		else $error("lock indication not on pin");
	a_status_fields: assert property (REG_RD && REG_ADDR == osr_pkg::OFS_STATUS && sel_path
		|=> REG_RDATA == {22'h00_0000, $past(LOCK_IND, 3), SDO_O}) else $error("status read wrong");
	a_selftest_fields: assert property (REG_RD && REG_ADDR == osr_pkg::OFS_SELF
		|=> REG_RDATA == {7'h00, $past(SELF_TEST_RUNNING, 2), $past(SELF_TEST_SIGNATURE, 2)})
		else $error("self-test read wrong");
	a_reserved_zero: assert property (REG_RD && rsv_hit |=> REG_RDATA == 24'h00_0000)
		else $error("reserved read not zero");
	a_ctrl_readback: assert property (REG_RD && REG_ADDR == osr_pkg::OFS_CTRL
		|=> REG_RDATA == {14'h0000, $past(ctrl_q)}) else $error("control read wrong");
	c_selftest_read: cover property (REG_RD && REG_ADDR == osr_pkg::OFS_SELF);
	c_inhibited_frame: cover property (SPI_READ_ACTIVE && ctrl_q[6]);
	c_driver_kept: cover property (SDO_OE && !SPI_DRV_REQ);
endmodule
bind osr_top osr_properties u_props (.CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
	.SPI_READ_ACTIVE(SPI_READ_ACTIVE), .SPI_READ_BIT(SPI_READ_BIT), .SPI_DRV_REQ(SPI_DRV_REQ),
	.SELF_TEST_SIGNATURE(SELF_TEST_SIGNATURE), .SELF_TEST_RUNNING(SELF_TEST_RUNNING),
	.LOCK_IND(LOCK_IND), .SDO_O(SDO_O), .SDO_OE(SDO_OE));

// [verif/osr_host_model.sv]
// Host serial controller: shifts a readback word and captures the pin.
// Assumes go pulses one cycle; a released pin shows the inverse level.
`timescale 1ns/1ps
module osr_host_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [7:0] word,
	input  wire logic       sdo_o,
	input  wire logic       sdo_oe,
	output logic            act,
	output logic            bit_o,
	output logic            drv,
	output logic [7:0]      got
);
	logic [7:0] sr_q;
	logic [3:0] cnt_q;
	logic       act_d_q;
	logic       last_q;
	wire        pin = sdo_oe ? sdo_o : ~last_q;
	// Word goes out MSB first; pin captured one cycle behind
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{sr_q, cnt_q, act_d_q, last_q, act, bit_o, drv, got} <= '0;
		end else begin
			act_d_q <= act;
			last_q  <= pin;
			if (act_d_q)
				got <= {got[6:0], pin};
			if (go) begin
				sr_q  <= word;
				cnt_q <= 4'h8;
			end else if (cnt_q != 4'h0) begin
				{act, drv, bit_o} <= {2'b11, sr_q[7]};
				sr_q  <= {sr_q[6:0], 1'b0};
				cnt_q <= cnt_q - 4'h1;
			end else begin
				{act, drv, bit_o} <= {2'b00, ~bit_o};
			end
		end
	end
endmodule

// [verif/tb.sv]
// Self-checking bench for output selection and status readback.
// Assumes a 40 MHz clock and the host model watching the data out pin.
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] USED = 32'hC3FF_7F7F;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, running = 1'b0;
	logic [5:0]  addr = 6'h00;
	logic [23:0] wdata = 24'h00_0000;
	logic [15:0] sig = 16'h0000;
	logic [31:0] src = 32'h0000_0000;
	logic [7:0]  word = 8'h00;
	logic [7:0]  got;
	logic [23:0] rdata;
	logic        rvalid, act, rbit, drv, sdo, oe, pu_off, dn_off;
	int          fails = 0;
	int          check_count = 0;
	always #12.5 clk = ~clk;
	osr_top u_dut (.CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .REG_RVALID(rvalid), .SPI_READ_ACTIVE(act), .SPI_READ_BIT(rbit),
		.SPI_DRV_REQ(drv), .SELF_TEST_SIGNATURE(sig), .SELF_TEST_RUNNING(running), .LOCK_IND(src[1]),
		.LOCK_TRIG(src[2]), .LOCK_WIN(src[3]), .RING_OSC_TEST(src[4]), .CYCLE_SLIP_PULL_UP(src[5]),
		.CYCLE_SLIP_PULL_DN(src[6]), .REF_BUF_OUT(src[8]), .REF_DIV_OUT(src[9]), .FB_DIV_OUT(src[10]),
		.MOD_CLK(src[11]), .AUX_CLK(src[12]), .AUXP_CLK(src[13]), .AUXP_DATA(src[14]),
		.PHASE_DET_DN(src[16]), .PHASE_DET_UP(src[17]), .MOD_CLK_DLY(src[18]), .MOD_CORE_CLK(src[19]),
		.STROBE_INT(src[20]), .STROBE_FRAC(src[21]), .STROBE_AUX(src[22]), .SPI_LATCH_EN(src[23]),
		.FB_SYNC_RST(src[24]), .SEED_LOAD(src[25]), .SPI_OUT_BUF_EN(src[30]), .SOFT_RESET_LOW(src[31]),
		.SDO_O(sdo), .SDO_OE(oe), .PULLUP_TRANSISTOR_OFF(pu_off), .PULLDOWN_TRANSISTOR_OFF(dn_off));
	osr_host_model u_host (.clk(clk), .rst(rst), .go(go), .word(word), .sdo_o(sdo), .sdo_oe(oe),
		.act(act), .bit_o(rbit), .drv(drv), .got(got));
	// Compare and count
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Register access: one-cycle strobes, read answer one cycle later
	task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [5:0] a, input logic [23:0] e);
		@(posedge clk);
		{rd, addr} <= {1'b1, a};
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rvalid", 24'h00_0001, {23'h00_0000, rvalid});
		chk("rdata", e, rdata);
	endtask
	// One readback frame from the host
	task automatic send(input logic [7:0] w);
		@(posedge clk);
		{go, word} <= {1'b1, w};
		@(posedge clk);
		go <= 1'b0;
		idle(12);
	endtask
	task automatic print_verdict;
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		idle(5);
		rst <= 1'b0;
		rd_reg(osr_pkg::OFS_CTRL, 24'h00_0001);
		rd_reg(osr_pkg::OFS_STATUS, 24'h00_0000);
		rd_reg(osr_pkg::OFS_SELF, 24'h00_0000);
		for (int a = osr_pkg::OFS_RSV_A; a <= osr_pkg::OFS_SELF; a++) begin
			wr_reg(6'(a), 24'hFF_FFFF);
		end
		rd_reg(osr_pkg::OFS_CTRL, 24'h00_0001);
		rd_reg(osr_pkg::OFS_RSV_A, 24'h00_0000);
		rd_reg(osr_pkg::OFS_RSV_B, 24'h00_0000);
		rd_reg(osr_pkg::OFS_SELF, 24'h00_0000);
		rd_reg(6'h3f, 24'h00_0000);
		for (int c = 0; c < 32; c++) begin
			wr_reg(osr_pkg::OFS_CTRL, 24'(c) | ((c == 0) ? 24'h00_0020 : 24'h00_0000));
			src <= 32'hFFFF_FFFF;
			idle(6);
			#1 chk("sdo_high", {23'h00_0000, USED[c]}, {23'h00_0000, sdo});
			rd_reg(osr_pkg::OFS_STATUS, {22'h00_0000, 1'b1, USED[c]});
			src <= 32'h0000_0000;
			idle(6);
			#1 chk("sdo_low", {23'h00_0000, c == 0}, {23'h00_0000, sdo});
		end
		wr_reg(osr_pkg::OFS_CTRL, 24'h00_0001);
		send(8'hA5);
		chk("shared", 24'h00_00A5, {16'h0000, got});
		wr_reg(osr_pkg::OFS_CTRL, 24'h00_0060);
		send(8'h3C);
		chk("inhibited", 24'h00_00FF, {16'h0000, got});
		#1 chk("oe_idle", 24'h00_0000, {23'h00_0000, oe});
		wr_reg(osr_pkg::OFS_CTRL, 24'h00_0380);
		idle(2);
		#1 chk("oe_kept", 24'h00_0001, {23'h00_0000, oe});
		chk("fet_off", 24'h00_0003, {22'h00_0000, dn_off, pu_off});
		rd_reg(osr_pkg::OFS_CTRL, 24'h00_0380);
		{sig, running} <= {16'h5A3C, 1'b1};
		rd_reg(osr_pkg::OFS_SELF, 24'h01_5A3C);
		running <= 1'b0;
		rd_reg(osr_pkg::OFS_SELF, 24'h00_5A3C);
		// Mid-run reset brings the control register back to its default
		@(posedge clk);
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		rd_reg(osr_pkg::OFS_CTRL, 24'h00_0001);
		chk("oe_reset", 24'h00_0000, {23'h00_0000, oe});
		chk("fet_reset", 24'h00_0000, {22'h00_0000, dn_off, pu_off});
		print_verdict();
	end
endmodule
